/* File: rtl/fcbu_pkg.sv */
// fcbu_pkg: widths, encodings, reset values and carrier structs of the
// flag conditional branch unit.
// assumes the core decodes the instruction word into fcbu_instr_s.
package fcbu_pkg;

   localparam int unsigned PC_W  = 16;   // program counter, word address
   localparam int unsigned OFF_W = 7;    // signed word offset field
   localparam logic [PC_W-1:0]  PC_RESET  = 16'h0000;
   localparam logic [PC_W-1:0]  PC_STEP   = 16'h0001;
   localparam logic [OFF_W-1:0] OFF_RESET = 7'h00;
   // cycles from acceptance to completion
   localparam int unsigned CYC_NOT_TAKEN = 1;
   localparam int unsigned CYC_TAKEN     = 2;

   // decoded branch kind, one-hot; zero means not one of ours
   typedef enum logic [4:0] {
      KIND_NONE        = 5'h00,
      BRANCH_HALF_CARRY_CLEAR   = 5'h01,
      BRANCH_TRANSFER_BIT_SET   = 5'h02,
      BRANCH_TRANSFER_BIT_CLEAR = 5'h04,
      BRANCH_OVERFLOW_SET       = 5'h08,
      BRANCH_OVERFLOW_CLEAR     = 5'h10
   } fcbu_kind_e;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'h1,
      ST_FLUSH = 2'h2
   } fcbu_state_e;

   typedef struct packed {
      logic halfCarry;
      logic transferBit;
      logic overflow;
   } fcbu_flags_s;

   typedef struct packed {
      logic             valid;
      fcbu_kind_e       kind;
      logic [OFF_W-1:0] offset;
   } fcbu_instr_s;

   typedef struct packed {
      fcbu_state_e     state;
      logic [PC_W-1:0] pcOut;
      logic            pcLoad;
      logic            flush;
      logic            done;
      logic            taken;
      logic            ready;
      logic            flagWrite;
   } fcbu_state_s;

endpackage

/* File: rtl/fcbu_cond.sv */
// fcbu_cond: decides whether a decoded branch is taken from the flags.
// assumes kind is one-hot or zero; zero never yields a taken branch.
`timescale 1ns/1ps
module fcbu_cond
   import fcbu_pkg::*;
(
   input  wire fcbu_pkg::fcbu_kind_e  kind,
   input  wire fcbu_pkg::fcbu_flags_s flags,
   output logic                       taken
);

   // one case arm per kind; any other value, zero included, is not taken
   always_comb begin
      taken = 1'b0;
      case (kind)
         BRANCH_HALF_CARRY_CLEAR:   taken = !flags.halfCarry;
         BRANCH_TRANSFER_BIT_SET:   taken = flags.transferBit;
         BRANCH_TRANSFER_BIT_CLEAR: taken = !flags.transferBit;
         BRANCH_OVERFLOW_SET:       taken = flags.overflow;
         BRANCH_OVERFLOW_CLEAR:     taken = !flags.overflow;
         default:                   taken = 1'b0;
      endcase
   end

endmodule

/* File: rtl/fcbu_branch_unit.sv */
// fcbu_branch_unit: execute slice for five flag-tested relative branches.
// assumes instr, flags and pc are stable in the cycle instr.valid and
// ready are both high; the core loads pc from pcOut when pcLoad pulses.
// Function
// - half carry clear: pc gets pc+k+1
// - transfer bit set: pc gets pc+k+1
// - transfer bit clear: pc gets pc+k+1
// - overflow set: pc gets pc+k+1
// - overflow clear: pc gets pc+k+1
`timescale 1ns/1ps
module fcbu_branch_unit
   import fcbu_pkg::*;
(
   input  wire                        clk,
   input  wire                        reset,
   input  wire fcbu_pkg::fcbu_instr_s instr,
   input  wire fcbu_pkg::fcbu_flags_s flags,
   input  wire logic [PC_W-1:0]       pc,
   output logic [PC_W-1:0]            pcOut,
   output logic                       pcLoad,
   output logic                       flush,
   output logic                       done,
   output logic                       taken,
   output logic                       ready,
   output logic                       flagWrite
);
   import fcbu_pkg::*;

   fcbu_state_s     st_reg;
   fcbu_state_s     st_next;
   logic            condTrue;
   logic            accept;
   logic [PC_W-1:0] offsetExt;
   logic [PC_W-1:0] target;
   logic [PC_W-1:0] seqPc;

   // condition evaluation kept apart so the kind table stays in one place
   fcbu_cond u_cond (
      .kind  (instr.kind),
      .flags (flags),
      .taken (condTrue)
   );

   // offset is a signed word count, sign-extended to pc width
   assign offsetExt = {{(PC_W-OFF_W){instr.offset[OFF_W-1]}}, instr.offset};
   assign target    = pc + offsetExt + PC_STEP;
   assign seqPc     = pc + PC_STEP;
   // only branches of ours are taken; others are left to the core
   assign accept    = instr.valid && st_reg.ready && (instr.kind != KIND_NONE);

   // next-state logic; pulses fall back to zero unless set below
   always_comb begin
      st_next           = st_reg;
      st_next.pcLoad    = 1'b0;
      st_next.flush     = 1'b0;
      st_next.done      = 1'b0;
      st_next.flagWrite = 1'b0;  // status flags are never written
      case (st_reg.state)
         ST_IDLE: begin
            if (accept) begin
               st_next.pcLoad = 1'b1;
               st_next.taken  = condTrue;
               if (condTrue) begin
                  // taken: prefetched word is stale, spend a second cycle
                  st_next.pcOut = target;
                  st_next.flush = 1'b1;
                  st_next.ready = 1'b0;
                  st_next.state = ST_FLUSH;
               end else begin
                  st_next.pcOut = seqPc;
                  st_next.done  = 1'b1;
               end
            end
         end
         ST_FLUSH: begin
            st_next.done  = 1'b1;
            st_next.ready = 1'b1;
            st_next.state = ST_IDLE;
         end
         default: begin
            st_next.ready = 1'b1;
            st_next.state = ST_IDLE;
         end
      endcase
   end

   // state register; reset leaves the unit idle and ready
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_reg.state     <= ST_IDLE;
         st_reg.pcOut     <= PC_RESET;
         st_reg.pcLoad    <= 1'b0;
         st_reg.flush     <= 1'b0;
         st_reg.done      <= 1'b0;
         st_reg.taken     <= 1'b0;
         st_reg.ready     <= 1'b1;
         st_reg.flagWrite <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs straight from the state flops
   assign pcOut     = st_reg.pcOut;
   assign pcLoad    = st_reg.pcLoad;
   assign flush     = st_reg.flush;
   assign done      = st_reg.done;
   assign taken     = st_reg.taken;
   assign ready     = st_reg.ready;
   assign flagWrite = st_reg.flagWrite;

   // checks: half carry clear ties its flag to the loaded pc, three kinds check pcOut for one outcome only; transfer bit clear is checked on taken
   sequence s_takenEnd;
      pcLoad && flush && !done ##1 done && !pcLoad && ready;
   endsequence

   sequence s_seqEnd;
      pcLoad && done && !flush && ready;
   endsequence

   property p_halfCarryClear;
      @(posedge clk) disable iff (reset)
      accept && instr.kind == BRANCH_HALF_CARRY_CLEAR
      |=> pcLoad && (pcOut == ($past(flags.halfCarry) ? $past(seqPc) : $past(target)));
   endproperty
   a_halfCarryClear: assert property (p_halfCarryClear)
      else $error("half carry clear branch loaded wrong pc");

   property p_transferSet;
      @(posedge clk) disable iff (reset)
      accept && instr.kind == BRANCH_TRANSFER_BIT_SET && flags.transferBit
      |=> s_takenEnd;
   endproperty
   a_transferSet: assert property (p_transferSet)
      else $error("transfer set branch not taken in two cycles");

   property p_transferClear;
      @(posedge clk) disable iff (reset)
      accept && instr.kind == BRANCH_TRANSFER_BIT_CLEAR
      |=> taken == !$past(flags.transferBit) && !flagWrite ##1 !flagWrite;
   endproperty
   a_transferClear: assert property (p_transferClear)
      else $error("transfer clear branch decision wrong");

   property p_overflowSet;
      @(posedge clk) disable iff (reset)
      accept && instr.kind == BRANCH_OVERFLOW_SET && !flags.overflow
      |=> s_seqEnd;
   endproperty
   a_overflowSet: assert property (p_overflowSet)
      else $error("overflow set branch did not fall through");

   property p_overflowClear;
      @(posedge clk) disable iff (reset)
      accept && instr.kind == BRANCH_OVERFLOW_CLEAR && !flags.overflow
      |=> pcOut == $past(target) ##1 done;
   endproperty
   a_overflowClear: assert property (p_overflowClear)
      else $error("overflow clear branch target wrong");

   property p_offsetSign;
      @(posedge clk) disable iff (reset)
      accept && condTrue && instr.offset == 7'h7f |=> pcOut == $past(pc);
   endproperty
   a_offsetSign: assert property (p_offsetSign)
      else $error("offset of minus one must branch to itself");

   property p_notTakenOneCycle;
      @(posedge clk) disable iff (reset)
      accept && !condTrue |=> s_seqEnd ##1 (!done || pcLoad);
   endproperty
   a_notTakenOneCycle: assert property (p_notTakenOneCycle)
      else $error("untaken branch must finish in one cycle");

   property p_noFlagWrite;
      @(posedge clk) disable iff (reset)
      $rose(pcLoad) |-> !flagWrite throughout (##[1:2] ready);
   endproperty
   a_noFlagWrite: assert property (p_noFlagWrite)
      else $error("branch must not write status flags");

   // a request in the flush cycle is dropped, the core must hold it
   property p_refuseBusy;
      @(posedge clk) disable iff (reset)
      instr.valid && !ready |=> !pcLoad;
   endproperty
   a_refuseBusy: assert property (p_refuseBusy)
      else $error("request during flush cycle was accepted");

   // foreign opcodes leave pc and completion alone
   property p_kindNoneIgnored;
      @(posedge clk) disable iff (reset)
      instr.valid && ready && instr.kind == KIND_NONE |=> !pcLoad && !done;
   endproperty
   a_kindNoneIgnored: assert property (p_kindNoneIgnored)
      else $error("foreign opcode started a branch");

   property p_transferSetFall;
      @(posedge clk) disable iff (reset)
      accept && instr.kind == BRANCH_TRANSFER_BIT_SET && !flags.transferBit
      |=> pcLoad && done && !flush && !taken && pcOut == $past(seqPc);
   endproperty
   a_transferSetFall: assert property (p_transferSetFall)
      else $error("transfer set branch did not fall through");

   property p_overflowSetTaken;
      @(posedge clk) disable iff (reset)
      accept && instr.kind == BRANCH_OVERFLOW_SET && flags.overflow
      |=> pcLoad && flush && taken && pcOut == $past(target) ##1 done && ready;
   endproperty
   a_overflowSetTaken: assert property (p_overflowSetTaken)
      else $error("overflow set branch not taken to target");

   property p_overflowClearFall;
      @(posedge clk) disable iff (reset)
      accept && instr.kind == BRANCH_OVERFLOW_CLEAR && flags.overflow
      |=> s_seqEnd;
   endproperty
   a_overflowClearFall: assert property (p_overflowClearFall)
      else $error("overflow clear branch did not fall through");

   // decision and target stand until the next load
   property p_takenHolds;
      @(posedge clk) disable iff (reset)
      !pcLoad |-> $stable(taken) && $stable(pcOut);
   endproperty
   a_takenHolds: assert property (p_takenHolds)
      else $error("taken or pcOut changed without a load");

endmodule

/* File: tb/tb.sv */
// tb: self-checking bench for the flag conditional branch unit.
// assumes the unit's own assertions sit in its design files.
`timescale 1ns/1ps
module tb;
   import fcbu_pkg::*;

   logic        clk;
   logic        reset;
   fcbu_instr_s instr;
   fcbu_flags_s flags;
   logic [15:0] pc;
   logic [15:0] pcOut;
   logic        pcLoad, flush, done, taken, ready, flagWrite;
   int          numErrors;
   int          samplesChecked;
   int          seed;
   int          idx;
   logic [31:0] rnd;
   fcbu_kind_e  kinds [6] = '{KIND_NONE, BRANCH_HALF_CARRY_CLEAR, BRANCH_TRANSFER_BIT_SET,
      BRANCH_TRANSFER_BIT_CLEAR, BRANCH_OVERFLOW_SET, BRANCH_OVERFLOW_CLEAR};

   fcbu_branch_unit dut_u (
      .clk       (clk),
      .reset     (reset),
      .instr     (instr),
      .flags     (flags),
      .pc        (pc),
      .pcOut     (pcOut),
      .pcLoad    (pcLoad),
      .flush     (flush),
      .done      (done),
      .taken     (taken),
      .ready     (ready),
      .flagWrite (flagWrite)
   );

   // 100 MHz core clock
   always #5 clk = ~clk;

   task automatic test_done();
      $display("checks %0d, mismatches %0d", samplesChecked, numErrors);
      if (numErrors == 0 && samplesChecked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
      samplesChecked++;
      if (got !== exp) begin
         numErrors++;
         $display("wrong value %s: expected %h, seen %h", name, exp, got);
      end
   endtask

   // condition per branch kind; unknown kinds never branch
   function automatic logic expTaken(fcbu_kind_e k, fcbu_flags_s f);
      case (k)
         BRANCH_HALF_CARRY_CLEAR:   return !f.halfCarry;
         BRANCH_TRANSFER_BIT_SET:   return f.transferBit;
         BRANCH_TRANSFER_BIT_CLEAR: return !f.transferBit;
         BRANCH_OVERFLOW_SET:       return f.overflow;
         BRANCH_OVERFLOW_CLEAR:     return !f.overflow;
         default:                   return 1'b0;
      endcase
   endfunction

   // one branch; a taken branch keeps valid up in the flush cycle to
   // prove that a request during ready low is ignored
   task automatic branch(fcbu_kind_e k, logic [2:0] f, logic [15:0] p, logic [6:0] o);
      logic        t;
      logic [15:0] tgt;
      t = expTaken(k, f);
      tgt = t ? p + {{9{o[6]}}, o} + 16'h0001 : p + 16'h0001;
      instr = '{1'b1, k, o};
      flags = f;
      pc = p;
      @(posedge clk);
      @(negedge clk);
      if (k == KIND_NONE) begin
         chk("pcLoad", 16'h0000, pcLoad);
         return;
      end
      chk("pcLoad", 16'h0001, pcLoad);
      chk("pcOut", tgt, pcOut);
      chk("taken", t, taken);
      chk("flush", t, flush);
      chk("done", !t, done);
      chk("ready", !t, ready);
      chk("flagWrite", 16'h0000, flagWrite);
      if (t) begin
         @(negedge clk);
         chk("done", 16'h0001, done);
         chk("ready", 16'h0001, ready);
         chk("pcLoad", 16'h0000, pcLoad);
      end
   endtask

   // hang guard: the tests need at most about 620 cycles
   initial begin
      #50000;
      numErrors++;
      test_done();
   end

   initial begin
      seed = 32'hcbc8;
      clk = 1'b0;
      reset = 1'b1;
      instr = '0;
      flags = '0;
      pc = 16'h0000;
      repeat (3) @(negedge clk);
      reset = 1'b0;
      chk("pcOut", PC_RESET, pcOut);
      chk("ready", 16'h0001, ready);
      chk("taken", 16'h0000, taken);
      $display("reset test ended");
      // each kind taken and not taken, at offset and pc boundaries
      branch(BRANCH_HALF_CARRY_CLEAR, 3'b011, 16'h0100, 7'h3f);
      branch(BRANCH_HALF_CARRY_CLEAR, 3'b100, 16'hffff, 7'h40);
      branch(BRANCH_TRANSFER_BIT_SET, 3'b010, 16'hffff, 7'h01);
      branch(BRANCH_TRANSFER_BIT_SET, 3'b101, 16'h0200, 7'h10);
      branch(BRANCH_TRANSFER_BIT_CLEAR, 3'b101, 16'h1000, 7'h7f);
      branch(BRANCH_TRANSFER_BIT_CLEAR, 3'b010, 16'h1000, 7'h7f);
      branch(BRANCH_OVERFLOW_SET, 3'b001, 16'h0010, 7'h40);
      branch(BRANCH_OVERFLOW_SET, 3'b110, 16'h0010, 7'h40);
      branch(BRANCH_OVERFLOW_CLEAR, 3'b110, 16'h8000, 7'h00);
      branch(BRANCH_OVERFLOW_CLEAR, 3'b001, 16'h8000, 7'h00);
      branch(KIND_NONE, 3'b000, 16'h1234, 7'h05);
      $display("corner test ended");
      for (int i = 0; i < 300; i++) begin
         idx = $unsigned($random(seed)) % 6;
         rnd = $random(seed);
         branch(kinds[idx], rnd[2:0], rnd[31:16], rnd[9:3]);
      end
      $display("random test ended");
      instr.valid = 1'b0;
      @(negedge clk);
      test_done();
   end
endmodule
